// *** logic/fdt_pkg.sv ***
/*
 * package for the deferred floating-point trap controller: register map,
 * status bit positions, instruction classes, trap-type codes, states.
 * assumes a single 10 MHz clock domain shared with the integer unit.
 */
package fdt_pkg;
	// ----------------------------------------------------------------
	// register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] FDT_ADDR_STATUS = 8'h00;
	localparam logic [7:0] FDT_ADDR_MASK = 8'h04;
	localparam logic [7:0] FDT_ADDR_FSR = 8'h08;
	localparam logic [7:0] FDT_ADDR_COUNT = 8'h0C;
	localparam int FDT_FSR_QNE_BIT = 13;
	localparam int FDT_FSR_FTT_LSB = 14;
	localparam int FDT_EV_TRAP = 0;
	localparam int FDT_EV_SEQ = 1;
	localparam int FDT_EV_UNIMP = 2;
	localparam int FDT_EV_LDFAULT = 3;
	localparam logic [3:0] FDT_MASK_RESET = 4'h0;
	localparam int FDT_QDEPTH_DEFAULT = 4;
	localparam logic [31:0] FDT_WORD_STEP = 32'h0000_0004;
	// ----------------------------------------------------------------
	// trap-type codes and operation decode
	// ----------------------------------------------------------------
	localparam logic [2:0] FDT_FTT_NONE = 3'h0;
	localparam logic [2:0] FDT_FTT_UNSUPPORTED = 3'h3;
	localparam logic [2:0] FDT_FTT_SEQUENCE = 3'h4;
	localparam logic [8:0] FDT_OPF_S_TO_D_MUL = 9'h069;
	localparam logic [8:0] FDT_OPF_D_TO_Q_MUL = 9'h06E;
	localparam logic [8:0] FDT_OPF_I_TO_Q = 9'h0CC;
	localparam logic [8:0] FDT_OPF_S_TO_Q = 9'h0CD;
	localparam logic [8:0] FDT_OPF_D_TO_Q = 9'h0CE;
	localparam logic [1:0] FDT_OPF_QUAD_SFX = 2'h3;
	localparam int FDT_OPF_LSB = 5;
	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FDT_EXECUTING = 2'b00,
		FDT_EXC_PENDING = 2'b01,
		FDT_EXC_HELD = 2'b10
	} fdt_state_e;
	typedef enum logic [2:0] {
		FDT_CL_OPERATE = 3'b000,
		FDT_CL_LOAD = 3'b001,
		FDT_CL_BRANCH = 3'b010,
		FDT_CL_STORE_QUEUE = 3'b011,
		FDT_CL_STORE_STATE = 3'b100,
		FDT_CL_STORE_OTHER = 3'b101
	} fdt_class_e;
	// one queue entry: instruction address, word, unsupported flag
	typedef struct packed {
		logic unsup;
		logic [31:0] addr;
		logic [31:0] instr;
	} fdt_entry_s;
endpackage : fdt_pkg

// *** logic/fdt_trap_ctrl.sv ***
/*
 * deferred floating-point trap controller: exception state machine,
 * deferred-trap queue, store-queue drain, sequence and unsupported checks,
 * register port with sticky status and masked interrupt.
 * assumes the integer unit issues one instruction per accepted cycle and
 * reports completion or exception of the oldest pending operate in order.
 */
// What this block does
// - keep a queue of doubleword entries for operates pending at exception time.
// - after trap the head entry holds faulting operate address and word.
// - entries behind the head hold operates not yet finished at trap.
// - store-queue writes head address at effective address, word at plus four.
// - each store-queue advances or empties queue; queue-not-empty flag follows.
// - three-state machine, resting in executing state.
// - operate exception while executing moves to pending, with no trap.
// - any fp instruction while pending moves to held and requests trap; the queue is left as it stands.
// - trap request only on the pending to held transition.
// - while held only fp stores run, none of them trap.
// - leave held for executing only when store-queue empties the queue.
// - operate, load or branch while held returns to pending, sequence code.
// - instruction causing a sequence error never enters the queue.
// - faulting fp load sets all its destination registers to all ones.
// - unsupported operate sets unsupported code and raises an exception.
// - quad, single-to-double and double-to-quad multiplies are unsupported.
// - queue depth is a parameter; behaviour otherwise identical.
module fdt_trap_ctrl
	import fdt_pkg::*;
#(
	parameter int QDEPTH = FDT_QDEPTH_DEFAULT
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_issue_valid,
	input wire fdt_class_e i_issue_class,
	input wire logic [31:0] i_issue_instr,
	input wire logic [31:0] i_issue_addr,
	input wire logic [31:0] i_issue_ea,
	input wire logic i_op_done,
	input wire logic i_op_exc,
	input wire logic [2:0] i_op_exc_ftt,
	input wire logic i_load_fault,
	input wire logic [4:0] i_load_rd,
	input wire logic i_load_dbl,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic o_issue_ready,
	output logic o_fp_trap,
	output logic o_qne,
	output logic [2:0] o_ftt,
	output logic [1:0] o_state,
	output logic o_st_en,
	output logic [31:0] o_st_addr0,
	output logic [31:0] o_st_data0,
	output logic [31:0] o_st_addr1,
	output logic [31:0] o_st_data1,
	output logic o_freg_wr_en,
	output logic [4:0] o_freg_wr_addr,
	output logic o_freg_wr_dbl,
	output logic [63:0] o_freg_wr_data,
	output logic o_irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		fdt_state_e state;
		logic [7:0] cnt;
		logic [2:0] ftt;
		logic [3:0] sts;
		logic [3:0] msk;
		logic [31:0] rdata;
		logic ready;
		logic trap;
		logic st_en;
		logic [31:0] st_addr0;
		logic [31:0] st_data0;
		logic [31:0] st_addr1;
		logic [31:0] st_data1;
		logic fw_en;
		logic [4:0] fw_addr;
		logic fw_dbl;
		logic [63:0] fw_data;
		logic irq;
		logic qne;
	} fdt_regs_s;

	localparam logic [7:0] DEPTH8 = 8'(QDEPTH);

	fdt_regs_s r_q;
	fdt_regs_s r_d;
	fdt_entry_s queue_q [QDEPTH];
	fdt_entry_s queue_d [QDEPTH];

	// quad ops, quad conversions and the two widening multiplies
	function automatic logic is_unsupported(input logic [31:0] instr);
		logic [8:0] opf;
		opf = instr[FDT_OPF_LSB +: 9];
		is_unsupported = (opf[1:0] == FDT_OPF_QUAD_SFX)
			|| (opf == FDT_OPF_S_TO_D_MUL)
			|| (opf == FDT_OPF_D_TO_Q_MUL)
			|| (opf == FDT_OPF_I_TO_Q)
			|| (opf == FDT_OPF_S_TO_Q)
			|| (opf == FDT_OPF_D_TO_Q);
	endfunction : is_unsupported

	// register file view of the state register
	function automatic logic [31:0] fsr_view(input fdt_regs_s r);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[1:0] = r.state;
		v[FDT_FSR_QNE_BIT] = (r.cnt != 8'h00);
		v[FDT_FSR_FTT_LSB +: 3] = r.ftt;
		fsr_view = v;
	endfunction : fsr_view

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic take;
		logic pop;
		logic push;
		logic exc;
		logic [3:0] ev;
		logic [7:0] cnt;
		fdt_entry_s ent;
		take = 1'b0;
		pop = 1'b0;
		push = 1'b0;
		exc = 1'b0;
		ev = 4'h0;
		cnt = r_q.cnt;
		ent = '0;
		r_d = r_q;
		queue_d = queue_q;
		r_d.trap = 1'b0;
		r_d.st_en = 1'b0;
		r_d.fw_en = 1'b0;
		r_d.rdata = 32'h0000_0000;
		take = i_issue_valid && r_q.ready;

		// executing: retire head, detect exceptions, accept operates
		case (r_q.state)
			FDT_EXECUTING: begin
				if (r_q.cnt != 8'h00 && queue_q[0].unsup) begin
					exc = 1'b1;
					ev[FDT_EV_UNIMP] = 1'b1;
					r_d.ftt = FDT_FTT_UNSUPPORTED;
				end else if (r_q.cnt != 8'h00 && i_op_exc) begin
					exc = 1'b1;
					r_d.ftt = i_op_exc_ftt;
				end else if (r_q.cnt != 8'h00 && i_op_done) begin
					pop = 1'b1;
				end
				if (exc) begin
					// head stays: it is the faulting operate
					r_d.state = FDT_EXC_PENDING;
				end
				if (take && i_issue_class == FDT_CL_OPERATE) begin
					push = 1'b1;
				end
			end
			FDT_EXC_PENDING: begin
				if (take) begin
					// queue already holds the faulting operate at its head
					r_d.state = FDT_EXC_HELD;
					r_d.trap = 1'b1;
					ev[FDT_EV_TRAP] = 1'b1;
				end
			end
			FDT_EXC_HELD: begin
				if (take) begin
					case (i_issue_class)
						FDT_CL_STORE_QUEUE: begin
							r_d.st_en = 1'b1;
							r_d.st_addr0 = i_issue_ea;
							r_d.st_data0 = queue_q[0].addr;
							r_d.st_addr1 = i_issue_ea + FDT_WORD_STEP;
							r_d.st_data1 = queue_q[0].instr;
							if (r_q.cnt != 8'h00) begin
								pop = 1'b1;
							end
							if (r_q.cnt <= 8'h01) begin
								r_d.state = FDT_EXECUTING;
							end
						end
						FDT_CL_OPERATE, FDT_CL_LOAD, FDT_CL_BRANCH: begin
							// not entered into the queue
							r_d.state = FDT_EXC_PENDING;
							r_d.ftt = FDT_FTT_SEQUENCE;
							ev[FDT_EV_SEQ] = 1'b1;
						end
						default: begin
							// other stores run without trapping
							r_d.state = FDT_EXC_HELD;
						end
					endcase
				end
			end
			default: begin
				r_d.state = FDT_EXECUTING;
			end
		endcase

		// queue shift on pop, then append on push
		if (pop) begin
			for (int i = 0; i < QDEPTH - 1; i++) begin
				queue_d[i] = queue_q[i + 1];
			end
			queue_d[QDEPTH - 1] = '0;
			cnt = r_q.cnt - 8'h01;
		end
		if (push) begin
			ent.unsup = is_unsupported(i_issue_instr);
			ent.addr = i_issue_addr;
			ent.instr = i_issue_instr;
			for (int i = 0; i < QDEPTH; i++) begin
				if (8'(i) == cnt) begin
					queue_d[i] = ent;
				end
			end
			cnt = cnt + 8'h01;
		end
		r_d.cnt = cnt;
		r_d.qne = (cnt != 8'h00);

		// faulting load writes ones into its destinations
		if (i_load_fault) begin
			r_d.fw_en = 1'b1;
			r_d.fw_addr = i_load_rd;
			r_d.fw_dbl = i_load_dbl;
			r_d.fw_data = {64{1'b1}};
			ev[FDT_EV_LDFAULT] = 1'b1;
		end

		// issue stalls only while executing with a full queue
		r_d.ready = !(r_d.state == FDT_EXECUTING && r_d.cnt == DEPTH8);

		// register writes: write one to clear, a new event wins
		if (i_reg_wr && i_reg_addr == FDT_ADDR_STATUS) begin
			r_d.sts = r_q.sts & ~i_reg_wdata[3:0];
		end
		if (i_reg_wr && i_reg_addr == FDT_ADDR_MASK) begin
			r_d.msk = i_reg_wdata[3:0];
		end
		r_d.sts = r_d.sts | ev;

		// register reads: data stands one cycle after the strobe
		if (i_reg_rd) begin
			case (i_reg_addr)
				FDT_ADDR_STATUS: r_d.rdata = {28'h000_0000, r_q.sts};
				FDT_ADDR_MASK: r_d.rdata = {28'h000_0000, r_q.msk};
				FDT_ADDR_FSR: r_d.rdata = fsr_view(r_q);
				FDT_ADDR_COUNT: r_d.rdata = {24'h00_0000, r_q.cnt};
				default: r_d.rdata = 32'h0000_0000;
			endcase
		end
		r_d.irq = |(r_d.sts & r_d.msk);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_q <= '0;
			r_q.state <= FDT_EXECUTING;
			r_q.cnt <= 8'h00;
			r_q.ftt <= FDT_FTT_NONE;
			r_q.msk <= FDT_MASK_RESET;
			r_q.ready <= 1'b1;
			for (int i = 0; i < QDEPTH; i++) begin
				queue_q[i] <= '0;
			end
		end else begin
			r_q <= r_d;
			queue_q <= queue_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign o_reg_rdata = r_q.rdata;
	assign o_issue_ready = r_q.ready;
	assign o_fp_trap = r_q.trap;
	assign o_qne = r_q.qne;
	assign o_ftt = r_q.ftt;
	assign o_state = r_q.state;
	assign o_st_en = r_q.st_en;
	assign o_st_addr0 = r_q.st_addr0;
	assign o_st_data0 = r_q.st_data0;
	assign o_st_addr1 = r_q.st_addr1;
	assign o_st_data1 = r_q.st_data1;
	assign o_freg_wr_en = r_q.fw_en;
	assign o_freg_wr_addr = r_q.fw_addr;
	assign o_freg_wr_dbl = r_q.fw_dbl;
	assign o_freg_wr_data = r_q.fw_data;
	assign o_irq = r_q.irq;
endmodule : fdt_trap_ctrl

// *** tb/fdt_trap_ctrl_sva.sv ***
/*
 * checker for the deferred trap controller: state, trap, store-queue, load fault.
 * assumes it is bound to fdt_trap_ctrl and sees only its ports.
 */
module fdt_trap_ctrl_sva
	import fdt_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_issue_valid,
	input wire fdt_class_e i_issue_class,
	input wire logic [31:0] i_issue_ea,
	input wire logic i_reg_rd,
	input wire logic i_load_fault,
	input wire logic [4:0] i_load_rd,
	input wire logic o_issue_ready,
	input wire logic o_fp_trap,
	input wire logic o_qne,
	input wire logic [2:0] o_ftt,
	input wire logic [1:0] o_state,
	input wire logic o_st_en,
	input wire logic [31:0] o_st_addr0,
	input wire logic [31:0] o_st_addr1,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_freg_wr_en,
	input wire logic [4:0] o_freg_wr_addr,
	input wire logic [63:0] o_freg_wr_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic take;
	// issue accepted this edge
	assign take = i_issue_valid && o_issue_ready;
	trap_on_entry_a:
	assert property (o_fp_trap |-> o_state == FDT_EXC_HELD && $past(o_state) == FDT_EXC_PENDING)
		else $error("trap outside pending to held");
	pend_take_a:
	assert property (o_state == FDT_EXC_PENDING && take |=> o_fp_trap && o_state == FDT_EXC_HELD)
		else $error("pending issue did not trap");
	seq_error_a:
	assert property (o_state == FDT_EXC_HELD && take
		&& i_issue_class inside {FDT_CL_OPERATE, FDT_CL_LOAD, FDT_CL_BRANCH}
		|=> o_state == FDT_EXC_PENDING && o_ftt == FDT_FTT_SEQUENCE && !o_fp_trap)
		else $error("sequence error not flagged");
	held_store_a:
	assert property (o_state == FDT_EXC_HELD && take
		&& i_issue_class inside {FDT_CL_STORE_STATE, FDT_CL_STORE_OTHER}
		|=> o_state == FDT_EXC_HELD && !o_fp_trap)
		else $error("store in held changed state");
	held_exit_a:
	assert property (o_state == FDT_EXECUTING && $past(o_state) == FDT_EXC_HELD
		|-> !o_qne && $past(take) && $past(i_issue_class) == FDT_CL_STORE_QUEUE)
		else $error("held left without draining");
	sq_write_a:
	assert property (o_state == FDT_EXC_HELD && take && i_issue_class == FDT_CL_STORE_QUEUE
		&& o_qne |=> o_st_en && o_st_addr0 == $past(i_issue_ea))
		else $error("store-queue write missing");
	st_pair_a:
	assert property (o_st_en |-> o_st_addr1 == o_st_addr0 + 32'h0000_0004)
		else $error("second word not at plus four");
	load_ones_a:
	assert property (i_load_fault |=> o_freg_wr_en && o_freg_wr_addr == $past(i_load_rd)
		&& o_freg_wr_data == 64'hFFFF_FFFF_FFFF_FFFF)
		else $error("faulting load not all ones");
	rdata_idle_a:
	assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	state_legal_a:
	assert property (o_state != 2'b11)
		else $error("illegal state code");
	cover property (o_fp_trap);
	cover property (o_st_en && o_qne);
	cover property (o_state == FDT_EXC_PENDING && o_ftt == FDT_FTT_SEQUENCE);
endmodule : fdt_trap_ctrl_sva
bind fdt_trap_ctrl fdt_trap_ctrl_sva fdt_trap_ctrl_sva_i (.*);

// *** tb/fdt_iu_model.sv ***
/*
 * integer-unit model: offers one fp instruction and holds it until taken, for 20 cycles at most.
 * assumes issue is called right after a rising clock edge.
 */
module fdt_iu_model
	import fdt_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_ready,
	output logic o_valid,
	output fdt_class_e o_class,
	output logic [31:0] o_instr,
	output logic [31:0] o_addr,
	output logic [31:0] o_ea
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_valid = 1'b0;
		o_class = FDT_CL_STORE_OTHER;
		o_instr = 32'h0000_0000;
		o_addr = 32'h0000_0000;
		o_ea = 32'h0000_0000;
	end
	// hold until ready at an edge, at most 20 cycles; idle instruction, address and ea lines show the inverse, the class line a stale copy
	task automatic issue(input fdt_class_e c, input logic [31:0] w, a, e);
		int n;
		logic r;
		o_valid <= 1'b1;
		o_class <= c;
		o_instr <= w;
		o_addr <= a;
		o_ea <= e;
		n = 0;
		// ready is sampled mid-cycle, so the edge that takes the request is known
		do begin
			@(negedge i_clock);
			r = i_ready;
			@(posedge i_clock);
			n++;
		end while (r !== 1'b1 && n < 20);
		o_valid <= 1'b0;
		o_instr <= ~w;
		o_addr <= ~a;
		o_ea <= ~e;
	endtask : issue
endmodule : fdt_iu_model

// *** tb/testbench.sv ***
/*
 * testbench for the deferred trap controller: issue, completion, register port.
 * assumes a 10 MHz clock and a queue depth of 2.
 */
module testbench
	import fdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'b0, i_rst_n = 1'b0, valid, ready, trap, qne, st_en, fw_en, fw_dbl, irq;
	logic op_done = 1'b0, op_exc = 1'b0, ld_fault = 1'b0, r_wr = 1'b0, r_rd = 1'b0;
	logic [31:0] instr, addr, ea, r_wdata = 32'h0000_0000, rdata, rd_val, sa0, sd0, sa1, sd1;
	logic [7:0] r_addr = 8'h00;
	logic [4:0] ld_rd = 5'h06, fw_addr;
	logic [2:0] ftt;
	logic [1:0] state;
	logic [63:0] fw_data;
	fdt_class_e cls;
	fdt_class_e sq[3] = '{FDT_CL_OPERATE, FDT_CL_LOAD, FDT_CL_BRANCH};
	logic [8:0] uo[3] = '{9'h069, 9'h06E, 9'h043};
	int miscompares = 0, comparisons = 0, cycles = 0;
	fdt_iu_model fdt_iu_model_i (.i_clock(i_clock), .i_ready(ready), .o_valid(valid),
		.o_class(cls), .o_instr(instr), .o_addr(addr), .o_ea(ea));
	fdt_trap_ctrl #(.QDEPTH(2)) fdt_trap_ctrl_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_issue_valid(valid), .i_issue_class(cls), .i_issue_instr(instr),
		.i_issue_addr(addr), .i_issue_ea(ea), .i_op_done(op_done), .i_op_exc(op_exc),
		.i_op_exc_ftt(3'h1), .i_load_fault(ld_fault), .i_load_rd(ld_rd), .i_load_dbl(1'b1),
		.i_reg_addr(r_addr), .i_reg_wdata(r_wdata), .i_reg_wr(r_wr), .i_reg_rd(r_rd),
		.o_reg_rdata(rdata), .o_issue_ready(ready), .o_fp_trap(trap), .o_qne(qne),
		.o_ftt(ftt), .o_state(state), .o_st_en(st_en), .o_st_addr0(sa0), .o_st_data0(sd0),
		.o_st_addr1(sa1), .o_st_data1(sd1), .o_freg_wr_en(fw_en), .o_freg_wr_addr(fw_addr),
		.o_freg_wr_dbl(fw_dbl), .o_freg_wr_data(fw_data), .o_irq(irq));
	// ----------------------------------------------------------------
	// clock, watchdog, tasks
	// ----------------------------------------------------------------
	initial begin
		forever #50 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles++;
		if (cycles > 3000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [71:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		r_wr <= 1'b1;
		r_addr <= a;
		r_wdata <= d;
		@(posedge i_clock);
		r_wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a);
		@(posedge i_clock);
		r_rd <= 1'b1;
		r_addr <= a;
		@(posedge i_clock);
		r_rd <= 1'b0;
		#1 rd_val = rdata;
	endtask : reg_rd
	task automatic iss(input fdt_class_e c, input logic [31:0] w, a, e);
		@(posedge i_clock);
		fdt_iu_model_i.issue(c, w, a, e);
		#1;
	endtask : iss
	task automatic pulse(input logic e);
		@(posedge i_clock);
		op_exc <= e;
		op_done <= !e;
		@(posedge i_clock);
		op_exc <= 1'b0;
		op_done <= 1'b0;
		#1;
	endtask : pulse
	task automatic settle;
		repeat (2) @(posedge i_clock);
		#1;
	endtask : settle
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		#1 chk({state, qne, ready}, {FDT_EXECUTING, 2'b01});
		$display("test reset done");
		iss(FDT_CL_OPERATE, 32'h0200_0820, 32'h0000_1000, 0);
		iss(FDT_CL_OPERATE, 32'h0400_0820, 32'h0000_1004, 0);
		chk(ready, 1'b0);
		pulse(1'b1);
		chk({state, trap}, {FDT_EXC_PENDING, 1'b0});
		iss(FDT_CL_BRANCH, 0, 0, 0);
		chk({state, trap}, {FDT_EXC_HELD, 1'b1});
		iss(FDT_CL_STORE_STATE, 0, 0, 0);
		chk({state, trap}, {FDT_EXC_HELD, 1'b0});
		iss(FDT_CL_STORE_QUEUE, 0, 0, 32'h0000_2000);
		chk({st_en, sa0, sd0}, {1'b1, 32'h0000_2000, 32'h0000_1000});
		chk({sa1, sd1}, {32'h0000_2004, 32'h0200_0820});
		chk({qne, state}, {1'b1, FDT_EXC_HELD});
		iss(FDT_CL_STORE_QUEUE, 0, 0, 32'h0000_2008);
		chk({sa0, sd0, qne, state}, {64'h0000_2008_0000_1004, 1'b0, FDT_EXECUTING});
		$display("test queue drain done");
		iss(FDT_CL_OPERATE, 32'h0600_0820, 32'h0000_1008, 0);
		pulse(1'b1);
		iss(FDT_CL_LOAD, 0, 0, 0);
		foreach (sq[k]) begin
			iss(sq[k], 32'h0800_0820, 32'h0000_100C, 0);
			chk({state, ftt}, {FDT_EXC_PENDING, FDT_FTT_SEQUENCE});
			iss(FDT_CL_STORE_STATE, 0, 0, 0);
			chk(trap, 1'b1);
		end
		iss(FDT_CL_STORE_QUEUE, 0, 0, 32'h0000_2010);
		chk({sd0, qne, state}, {32'h0000_1008, 1'b0, FDT_EXECUTING});
		$display("test sequence error done");
		foreach (uo[k]) begin
			iss(FDT_CL_OPERATE, {18'h0_0000, uo[k], 5'h00}, 32'h0000_1010, 0);
			settle();
			chk({state, ftt}, {FDT_EXC_PENDING, FDT_FTT_UNSUPPORTED});
			iss(FDT_CL_STORE_STATE, 0, 0, 0);
			iss(FDT_CL_STORE_QUEUE, 0, 0, 32'h0000_2018);
			chk({sd1, state}, {18'h0_0000, uo[k], 5'h00, FDT_EXECUTING});
		end
		$display("test unsupported done");
		iss(FDT_CL_OPERATE, 32'h0200_0820, 32'h0000_1000, 0);
		pulse(1'b0);
		reg_rd(FDT_ADDR_COUNT);
		chk(rd_val, 0);
		reg_rd(8'h10);
		chk(rd_val, 0);
		reg_wr(FDT_ADDR_STATUS, 32'h0000_000F);
		reg_wr(FDT_ADDR_MASK, 32'h0000_0008);
		reg_rd(FDT_ADDR_MASK);
		chk(rd_val, 32'h0000_0008);
		@(posedge i_clock);
		ld_fault <= 1'b1;
		@(posedge i_clock);
		ld_fault <= 1'b0;
		#1 chk({fw_en, fw_dbl, fw_addr, fw_data}, {2'b11, 5'h06, 64'hFFFF_FFFF_FFFF_FFFF});
		settle();
		chk(irq, 1'b1);
		reg_rd(FDT_ADDR_STATUS);
		chk(rd_val, 32'h0000_0008);
		reg_wr(FDT_ADDR_MASK, 32'h0000_0000);
		settle();
		chk(irq, 1'b0);
		reg_wr(FDT_ADDR_MASK, 32'h0000_0008);
		reg_wr(FDT_ADDR_STATUS, 32'h0000_0008);
		settle();
		chk(irq, 1'b0);
		reg_rd(FDT_ADDR_FSR);
		chk({rd_val[13], rd_val[1:0]}, 3'b000);
		$display("test registers done");
		end_sim();
	end
endmodule : testbench
